// ### core/drt_pkg.sv
// constants shared by the drive reset and thermal trip block
`default_nettype none
package drt_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFF_FUNC_ASSIGN = 8'h00;
    localparam logic [7:0] OFF_POLARITY    = 8'h04;
    localparam logic [7:0] OFF_OFF_DELAY   = 8'h08;
    localparam logic [7:0] OFF_LOGIC_REQ   = 8'h0C;
    localparam logic [7:0] OFF_STATUS      = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT    = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h18;

    // ==========================================================
    // field layout and codes
    localparam int         NUM_INPUTS     = 5;
    localparam int         FUNC_W         = 5;
    localparam int         NUM_LOGIC_OUT  = 3;
    localparam int         DELAY_W        = 8;
    localparam int         THERM_INPUT    = 4;
    localparam logic [4:0] FUNC_RESET     = 5'h12;
    localparam logic [4:0] FUNC_THERMAL   = 5'h13;
    localparam logic [5:0] TRIP_CODE_THERM = 6'h23;
    localparam logic [5:0] TRIP_CODE_NONE  = 6'h00;
    localparam int         IRQ_TRIP       = 0;
    localparam int         IRQ_RESET_DONE = 1;
    localparam int         IRQ_W          = 2;

    // ==========================================================
    // reset values
    localparam logic [24:0] FUNC_ASSIGN_RST = 25'h0000000;
    localparam logic [4:0]  POLARITY_RST    = 5'h00;
    localparam logic [23:0] OFF_DELAY_RST   = 24'h000000;
    localparam logic [2:0]  LOGIC_REQ_RST   = 3'h0;
    localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

    // ==========================================================
    // timing: figures as given, then cycle counts at the clock rate
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned RST_MIN_US     = 12000;
    localparam int unsigned ALARM_CLR_US   = 30000;
    localparam int unsigned OUT_HOLD_MS    = 1000;
    localparam int unsigned RST_MIN_CYC    = RST_MIN_US * CLK_MHZ;
    localparam int unsigned ALARM_CLR_CYC  = ALARM_CLR_US * CLK_MHZ;
    localparam int unsigned OUT_HOLD_CYC   = OUT_HOLD_MS * 1000 * CLK_MHZ;
    // display half swap period, slow enough for the eye to follow
    localparam int unsigned BLINK_CYC      = 20000000;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_PWRUP = 4'h1,
        ST_IDLE  = 4'h2,
        ST_HELD  = 4'h4,
        ST_APPLY = 4'h8
    } drt_state_e;
endpackage
`default_nettype wire

// ### core/drt_top.sv
// reset request sequencing, trip latch and thermistor trip path with apb registers
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
module drt_top #(
    parameter int unsigned RST_MIN_CYC  = drt_pkg::RST_MIN_CYC,
    parameter int unsigned OUT_HOLD_CYC = drt_pkg::OUT_HOLD_CYC,
    parameter int unsigned BLINK_CYC    = drt_pkg::BLINK_CYC
) (
    input  wire logic        CLK_SYS,          // system clock, 200 MHz
    input  wire logic        RST_N,            // synchronous reset, active low
    input  wire logic        CE,               // clock enable, freezes state when low
    input  wire logic [4:0]  GEN_IN,           // five general input pins
    input  wire logic        OVERTEMP_FLAG,    // thermistor front end flag on fifth input
    input  wire logic        RUN_CMD,          // run command from the drive control
    input  wire logic        PSEL,             // apb select
    input  wire logic        PENABLE,          // apb enable
    input  wire logic        PWRITE,           // apb direction
    input  wire logic [7:0]  PADDR,            // apb byte address
    input  wire logic [31:0] PWDATA,           // apb write data
    output logic             PREADY,           // apb ready
    output logic [31:0]      PRDATA,           // apb read data
    output logic             PSLVERR,          // apb error on unmapped address
    output logic             MOTOR_EN,         // motor output drive enable
    output logic [2:0]       LOGIC_OUT,        // logic outputs
    output logic             ALARM_OUT,        // alarm output
    output logic             TRIP_MODE,        // drive is in trip mode
    output logic [5:0]       TRIP_CODE,        // trip code shown on display
    output logic             DISP_ALT,         // display shows alternating segments
    output logic             DISP_PHASE,       // which segment half is lit
    output logic             IRQ               // level interrupt
);
    // ==========================================================
    // input synchronisers
    logic [4:0] gen_s1_q;
    logic [4:0] gen_s2_q;
    logic       th_s1_q;
    logic       th_s2_q;
    logic       run_s1_q;
    logic       run_s2_q;

    // pins come from outside the clock domain; two stages before use
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            gen_s1_q <= 5'h00;
            gen_s2_q <= 5'h00;
            th_s1_q  <= 1'b0;
            th_s2_q  <= 1'b0;
            run_s1_q <= 1'b0;
            run_s2_q <= 1'b0;
        end
        else if (CE)
        begin
            gen_s1_q <= GEN_IN;
            gen_s2_q <= gen_s1_q;
            th_s1_q  <= OVERTEMP_FLAG;
            th_s2_q  <= th_s1_q;
            run_s1_q <= RUN_CMD;
            run_s2_q <= run_s1_q;
        end
    end

    // ==========================================================
    // registers
    logic [24:0] func_q;
    logic [4:0]  pol_q;
    logic [23:0] dly_q;
    logic [2:0]  lreq_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_mask_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    // function field of one input
    function automatic logic [4:0] field_of(input logic [24:0] f, input int idx);
        field_of = f[idx*drt_pkg::FUNC_W +: drt_pkg::FUNC_W];
    endfunction

    // ==========================================================
    // apb decode
    wire setup_ph  = PSEL & ~PENABLE & CE;
    wire access_ph = PSEL & PENABLE & CE;
    wire wr_acc    = access_ph & PWRITE;
    wire hit_func  = (PADDR == drt_pkg::OFF_FUNC_ASSIGN);
    wire hit_pol   = (PADDR == drt_pkg::OFF_POLARITY);
    wire hit_dly   = (PADDR == drt_pkg::OFF_OFF_DELAY);
    wire hit_lreq  = (PADDR == drt_pkg::OFF_LOGIC_REQ);
    wire hit_stat  = (PADDR == drt_pkg::OFF_STATUS);
    wire hit_irqs  = (PADDR == drt_pkg::OFF_IRQ_STAT);
    wire hit_irqm  = (PADDR == drt_pkg::OFF_IRQ_MASK);
    wire mapped    = hit_func | hit_pol | hit_dly | hit_lreq | hit_stat | hit_irqs | hit_irqm;
    wire irqs_rd   = access_ph & ~PWRITE & hit_irqs;

    // thermal code refused off the fifth input
    logic [24:0] func_wr;
    always_comb
    begin
        func_wr = func_q;
        for (int i = 0; i < drt_pkg::NUM_INPUTS; i++)
        begin
            if (PWDATA[i*5 +: 5] != drt_pkg::FUNC_THERMAL || i == drt_pkg::THERM_INPUT)
            begin
                func_wr[i*5 +: 5] = PWDATA[i*5 +: 5];
            end
        end
    end

    // ==========================================================
    // input function decode
    logic [4:0] is_reset;
    always_comb
    begin
        is_reset = 5'h00;
        for (int i = 0; i < drt_pkg::NUM_INPUTS; i++)
        begin
            is_reset[i] = (field_of(func_q, i) == drt_pkg::FUNC_RESET);
        end
    end

    wire [4:0] eff_pol  = pol_q & ~is_reset;
    wire [4:0] in_level = gen_s2_q ^ eff_pol;
    wire       rst_in   = |(in_level & is_reset);
    // one flag covers hot and open
    wire       th_armed = (field_of(func_q, drt_pkg::THERM_INPUT) == drt_pkg::FUNC_THERMAL);
    wire       th_trip  = th_armed & th_s2_q;

    // off-delay parameter a, b, c each nonzero means a delayed output
    logic [2:0] dly_nz;
    always_comb
    begin
        for (int k = 0; k < drt_pkg::NUM_LOGIC_OUT; k++)
        begin
            dly_nz[k] = |dly_q[k*drt_pkg::DELAY_W +: drt_pkg::DELAY_W];
        end
    end

    // ==========================================================
    // reset sequencer
    drt_pkg::drt_state_e st_q;
    drt_pkg::drt_state_e st_d;
    logic [31:0]         held_q;
    logic                trip_q;
    logic                rst_in_q;
    logic [31:0]         hold_q;
    logic [2:0]          keep_q;
    logic [31:0]         blink_q;
    logic                phase_q;

    wire held_ok   = (held_q >= RST_MIN_CYC);
    wire rst_rise  = rst_in & ~rst_in_q;
    // delayed outputs are chosen from the requested levels, live in the onset cycle,
    // so a delayed output never blinks off for one cycle before keep_q loads
    wire [2:0] keep_now = rst_rise ? (lreq_q & dly_nz) : keep_q;
    wire apply     = (st_q == drt_pkg::ST_APPLY);
    // trip setting in the same cycle as a clear wins
    wire trip_set  = th_trip;
    wire trip_evt  = trip_set & ~trip_q;

    // act on release after a long enough hold
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            drt_pkg::ST_PWRUP: st_d = drt_pkg::ST_APPLY;
            drt_pkg::ST_IDLE:  if (rst_in) st_d = drt_pkg::ST_HELD;
            drt_pkg::ST_HELD:  if (!rst_in) st_d = held_ok ? drt_pkg::ST_APPLY : drt_pkg::ST_IDLE;
            drt_pkg::ST_APPLY: st_d = rst_in ? drt_pkg::ST_HELD : drt_pkg::ST_IDLE;
        endcase
    end

    // power-up enters the same apply step
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            st_q <= drt_pkg::ST_PWRUP;
        end
        else if (CE)
        begin
            st_q <= st_d;
        end
    end

    // hold-time counter saturates so long presses cannot wrap
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            held_q <= 32'h00000000;
        end
        else if (CE)
        begin
            if (st_q != drt_pkg::ST_HELD)
                held_q <= 32'h00000000;
            else if (!held_ok)
                held_q <= held_q + 32'h00000001;
        end
    end

    // trip latch held until a reset is applied
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            trip_q <= 1'b0;
        end
        else if (CE)
        begin
            if (trip_set)
                trip_q <= 1'b1;
            else if (apply)
                trip_q <= 1'b0;
        end
    end

    // outputs with off-delay kept about 1 s past reset onset
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            rst_in_q <= 1'b0;
            hold_q   <= 32'h00000000;
            keep_q   <= 3'h0;
        end
        else if (CE)
        begin
            rst_in_q <= rst_in;
            if (rst_rise)
            begin
                hold_q <= OUT_HOLD_CYC;
                keep_q <= lreq_q & dly_nz;
            end
            else if (hold_q != 32'h00000000)
                hold_q <= hold_q - 32'h00000001;
            else
                keep_q <= 3'h0;
        end
    end

    // segment halves swap while reset held
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            blink_q <= 32'h00000000;
            phase_q <= 1'b0;
        end
        else if (CE)
        begin
            if (!rst_in)
            begin
                blink_q <= 32'h00000000;
                phase_q <= 1'b0;
            end
            else if (blink_q >= BLINK_CYC - 32'd1)
            begin
                blink_q <= 32'h00000000;
                phase_q <= ~phase_q;
            end
            else
                blink_q <= blink_q + 32'h00000001;
        end
    end

    // ==========================================================
    // register writes and interrupt status
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            func_q     <= drt_pkg::FUNC_ASSIGN_RST;
            pol_q      <= drt_pkg::POLARITY_RST;
            dly_q      <= drt_pkg::OFF_DELAY_RST;
            lreq_q     <= drt_pkg::LOGIC_REQ_RST;
            irq_mask_q <= drt_pkg::IRQ_MASK_RST;
        end
        else if (wr_acc)
        begin
            if (hit_func) func_q     <= func_wr;
            if (hit_pol)  pol_q      <= PWDATA[4:0];
            if (hit_dly)  dly_q      <= PWDATA[23:0];
            if (hit_lreq) lreq_q     <= PWDATA[2:0];
            if (hit_irqm) irq_mask_q <= PWDATA[1:0];
        end
    end

    // read clears status; a new event in the same cycle still sets
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            irq_stat_q <= 2'h0;
        end
        else if (CE)
        begin
            // only bits already captured for the reader are cleared; an event that
            // lands between setup and access would otherwise be lost unseen
            irq_stat_q <= (irqs_rd ? (irq_stat_q & ~prdata_q[1:0]) : irq_stat_q)
                          | {apply, trip_evt};
        end
    end

    // ==========================================================
    // read data captured in setup so it is steady through access
    wire [31:0] rd_mux =
        hit_func ? {7'h00, func_q} :
        hit_pol  ? {27'h0000000, pol_q} :
        hit_dly  ? {8'h00, dly_q} :
        hit_lreq ? {29'h00000000, lreq_q} :
        hit_stat ? {18'h00000, TRIP_CODE, st_q, DISP_ALT, rst_in, ALARM_OUT, trip_q} :
        hit_irqs ? {30'h00000000, irq_stat_q} :
        hit_irqm ? {30'h00000000, irq_mask_q} : 32'h00000000;

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_q  <= PWRITE ? 32'h00000000 : rd_mux;
            pslverr_q <= ~mapped;
        end
    end

    // ==========================================================
    // outputs
    // alarm masked once the hold is accepted, well under 30 ms
    // mask also covers the apply cycle, else the alarm blips once before trip clears
    wire alarm_mask = ((st_q == drt_pkg::ST_HELD) & held_ok) | apply;

    assign PREADY    = CE;
    assign PRDATA    = prdata_q;
    assign PSLVERR   = pslverr_q;
    // threshold lives in the front end, no setting reaches it
    assign TRIP_MODE = trip_q;
    assign TRIP_CODE = trip_q ? drt_pkg::TRIP_CODE_THERM : drt_pkg::TRIP_CODE_NONE;
    assign ALARM_OUT = trip_q & ~alarm_mask;
    // motor drive drops at once, no ramp
    // run resumes once trip and reset are gone and the sequencer is past the power-up and apply steps
    assign MOTOR_EN  = run_s2_q & ~trip_q & ~rst_in & (st_q != drt_pkg::ST_PWRUP) & ~apply;
    // logic outputs drop while reset is held unless delayed; a trip leaves them at the requested levels
    assign LOGIC_OUT = rst_in ? keep_now : lreq_q;
    assign DISP_ALT  = rst_in;
    // phase register clears one edge after release; gate it so the display is normal at once
    assign DISP_PHASE = phase_q & rst_in;
    assign IRQ       = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

// ### tb/drt_contact_model.sv
// model of the reset contact and motor thermistor outside the drive
`default_nettype none
module drt_contact_model (
    input  wire logic  clk,    // system clock
    output logic [4:0] gen_in, // contact pins, pulled low when open
    output logic       hot     // thermistor hot or open
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        gen_in = 5'h00;
        hot = 1'b0;
    end
    // contact closed for a chosen number of cycles
    task automatic press(input int idx, input int cyc);
        @(posedge clk);
        gen_in[idx] <= 1'b1;
        repeat (cyc) @(posedge clk);
        gen_in[idx] <= 1'b0;
    endtask
    task automatic heat(input logic v);
        @(posedge clk);
        hot <= v;
    endtask
endmodule
`default_nettype wire

// ### tb/drt_top_sva.sv
// concurrent checks on the ports of the drive reset and thermal trip block
`default_nettype none
module drt_top_sva #(
    parameter int unsigned RST_MIN_CYC = 20
) (
    input wire logic        CLK_SYS,       // clock
    input wire logic        RST_N,         // reset, low
    input wire logic        CE,            // clock enable
    input wire logic        OVERTEMP_FLAG, // thermistor flag
    input wire logic        PSEL,          // apb select
    input wire logic        PENABLE,       // apb enable
    input wire logic        PWRITE,        // apb write
    input wire logic [7:0]  PADDR,         // apb address
    input wire logic [31:0] PWDATA,        // apb data
    input wire logic        PSLVERR,       // apb error
    input wire logic        MOTOR_EN,      // motor drive
    input wire logic        ALARM_OUT,     // alarm
    input wire logic        TRIP_MODE,     // trip
    input wire logic [5:0]  TRIP_CODE,     // trip code
    input wire logic        DISP_ALT,      // reset display
    input wire logic        DISP_PHASE     // blink phase
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        th_q;
    logic        th_d;
    logic [31:0] held_q;
    logic [31:0] held_d;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    // ==========================================
    // helpers
    // thermal enable snooped from bus writes, the checker cannot see registers
    assign th_d = (PSEL && PENABLE && PWRITE && CE && PADDR == 8'h00)
                  ? (PWDATA[24:20] == drt_pkg::FUNC_THERMAL) : th_q;
    // cycles the reset input has been seen held
    assign held_d = DISP_ALT ? held_q + 32'h1 : 32'h0;
    always_ff @(posedge CLK_SYS)
    begin
        th_q   <= RST_N & th_d;
        held_q <= RST_N ? held_d : 32'h0;
    end
    // ==========================================
    // assertions
    a_trip_code: assert property (
        TRIP_CODE == (TRIP_MODE ? drt_pkg::TRIP_CODE_THERM : 6'h00))
        else $error("trip code disagrees with trip state");
    a_motor_trip: assert property (TRIP_MODE |-> !MOTOR_EN)
        else $error("motor driven while tripped");
    a_motor_held: assert property (DISP_ALT |-> !MOTOR_EN)
        else $error("motor driven while reset held");
    a_alarm_trip: assert property (ALARM_OUT |-> TRIP_MODE)
        else $error("alarm without trip");
    a_alarm_bound: assert property (held_q > RST_MIN_CYC + 3 |-> !ALARM_OUT)
        else $error("alarm not cleared in time");
    a_therm_trip: assert property ((th_q && OVERTEMP_FLAG) [*4] |=> TRIP_MODE)
        else $error("hot thermistor did not trip");
    a_trip_latch: assert property (
        TRIP_MODE && !DISP_ALT && !$past(DISP_ALT) && !$past(DISP_ALT, 2)
        && !$past(DISP_ALT, 3) |=> TRIP_MODE)
        else $error("trip dropped without reset");
    a_phase_idle: assert property (!DISP_ALT |-> !DISP_PHASE)
        else $error("display blinks without reset");
    a_slverr_hole: assert property (PSEL && PENABLE && CE && PADDR > 8'h18 |-> PSLVERR)
        else $error("unmapped access without error");
    c_trip: cover property ($rose(TRIP_MODE));
    c_clear: cover property ($fell(TRIP_MODE));
    c_err: cover property (PSLVERR && PENABLE);
endmodule
bind drt_top drt_top_sva #(.RST_MIN_CYC(RST_MIN_CYC)) i_drt_top_sva (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .OVERTEMP_FLAG(OVERTEMP_FLAG), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
    .MOTOR_EN(MOTOR_EN), .ALARM_OUT(ALARM_OUT), .TRIP_MODE(TRIP_MODE),
    .TRIP_CODE(TRIP_CODE), .DISP_ALT(DISP_ALT), .DISP_PHASE(DISP_PHASE));
`default_nettype wire

// ### tb/tb_drt_top.sv
// self-checking testbench for the drive reset and thermal trip block
`default_nettype none
module tb_drt_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RMIN = 20;
    localparam int HOLD = 50;
    localparam int BLK  = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        run = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic        prdy, perr, mot, alm, trip, alt, ph, irq, hot;
    logic [31:0] prd;
    logic [2:0]  lout;
    logic [2:0]  lr;
    logic [5:0]  code;
    logic [4:0]  gin;
    logic [31:0] mreg [7] = '{default: 32'h0};
    logic [31:0] msk [7] = '{32'h1FFFFFF, 32'h1F, 32'hFFFFFF, 32'h7, 32'h0, 32'h0, 32'h3};
    logic [1:0]  mirq = 2'h0;
    logic        mtrip = 1'b0;
    int          errors = 0;
    int          comparisons = 0;
    always #2.5 clk = ~clk;
    drt_top #(.RST_MIN_CYC(RMIN), .OUT_HOLD_CYC(HOLD), .BLINK_CYC(BLK)) i_drt_top (
        .CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .GEN_IN(gin), .OVERTEMP_FLAG(hot),
        .RUN_CMD(run), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
        .PREADY(prdy), .PRDATA(prd), .PSLVERR(perr), .MOTOR_EN(mot), .LOGIC_OUT(lout),
        .ALARM_OUT(alm), .TRIP_MODE(trip), .TRIP_CODE(code), .DISP_ALT(alt),
        .DISP_PHASE(ph), .IRQ(irq));
    drt_contact_model i_drt_contact_model (.clk(clk), .gen_in(gin), .hot(hot));
    // ==========================================
    // checking and bus tasks
    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer; ready is waited for under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (prdy !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            summarize();
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        // thermal code kept off inputs one to four
        if (a == drt_pkg::OFF_FUNC_ASSIGN)
            for (int i = 0; i < 4; i++)
                if (d[5*i+:5] == drt_pkg::FUNC_THERMAL)
                    d[5*i+:5] = mreg[0][5*i+:5];
        mreg[a[4:2]] = d & msk[a[4:2]];
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", prd, x);
        chk("pslverr", perr, 32'(a > 8'h18));
    endtask
    // compare trip, code, alarm, motor, logic and irq outputs against the model state
    task automatic outs(input logic m, input logic [2:0] lo, input logic al);
        chk("trip", trip, mtrip);
        chk("code", code, mtrip ? drt_pkg::TRIP_CODE_THERM : 6'h00);
        chk("alarm", alm, al);
        chk("motor", mot, m);
        chk("logic", lout, lo);
        chk("irq", irq, 32'(|(mirq & mreg[6][1:0])));
    endtask
    // contact pulse with checks while held and after release
    task automatic pulse(input int idx, input int n, input logic [2:0] lo);
        logic p;
        fork
            i_drt_contact_model.press(idx, n);
            begin
                repeat (6) @(posedge clk);
                chk("disp_alt", alt, 1'b1);
                outs(1'b0, lo, mtrip);
                p = ph;
                repeat (BLK) @(posedge clk);
                chk("disp_phase", ph, !p);
                if (n > 90)
                begin
                    repeat (RMIN + 4) @(posedge clk);
                    outs(1'b0, lo, 1'b0);
                    repeat (HOLD) @(posedge clk);
                    outs(1'b0, 3'h0, 1'b0);
                end
            end
        join
        repeat (6) @(posedge clk);
        if (n >= RMIN)
        begin
            mtrip = 1'b0;
            mirq[1] = 1'b1;
        end
        chk("disp_alt", alt, 1'b0);
        outs(run & !mtrip, lr, mtrip);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(94));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        mirq = 2'h2;
        outs(1'b0, 3'h0, 1'b0);
        for (int i = 0; i < 7; i++)
            if (i < 4 || i == 6)
                rd(8'(4 * i), 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h14, 32'h2);
        mirq = 2'h0;
        rd(8'h14, 32'h0);
        lr = 3'($urandom) | 3'h1;
        wr(8'h00, {7'h0, 5'h13, 5'h00, 5'h00, 5'h13, 5'h12});
        rd(8'h00, mreg[0]);
        wr(8'h04, 32'h1);
        wr(8'h0C, {29'h0, lr});
        wr(8'h18, 32'h3);
        run <= 1'b1;
        repeat (6) @(posedge clk);
        chk("disp_alt", alt, 1'b0);
        outs(1'b1, lr, 1'b0);
        i_drt_contact_model.heat(1'b1);
        repeat (6) @(posedge clk);
        mtrip = 1'b1;
        mirq[0] = 1'b1;
        outs(1'b0, lr, 1'b1);
        i_drt_contact_model.heat(1'b0);
        repeat (6) @(posedge clk);
        outs(1'b0, lr, 1'b1);
        rd(8'h10, {18'h0, drt_pkg::TRIP_CODE_THERM, 4'(drt_pkg::ST_IDLE), 4'h3});
        rd(8'h14, 32'h1);
        mirq = 2'h0;
        pulse(0, RMIN / 2, 3'h0);
        pulse(0, RMIN + HOLD + 30, 3'h0);
        wr(8'h08, 32'h1);
        wr(8'h00, {7'h0, 5'h13, 5'h00, 5'h12, 5'h00, 5'h00});
        pulse(2, RMIN + HOLD + 30, lr & 3'h1);
        rd(8'h14, {30'h0, mirq});
        summarize();
    end
endmodule
`default_nettype wire
